// File: core/fes_pkg.sv
package fes_pkg;
	// stream widths
	localparam int DATA_W = 1;
	localparam int PARAM_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W = 16;

	// parameter word layout
	localparam int FI_HI = 15;
	localparam int FI_LO = 8;
	localparam int PI_BIT = 7;
	localparam int MT_HI = 6;
	localparam int MT_LO = 5;
	localparam int FS_BIT = 4;
	localparam int CR_HI = 3;
	localparam int CR_LO = 0;

	// coded frame lengths in bits
	localparam logic [CNT_W-1:0] N_NORMAL = 16'hFD20;
	localparam logic [CNT_W-1:0] N_SHORT = 16'h3F48;

	// uncoded frame lengths, index is the code rate field (0 = 1/4 .. 10 = 9/10)
	localparam logic [10:0][CNT_W-1:0] K_NORMAL = {
		16'hE350, 16'hE080, 16'hD250, 16'hC9C0, 16'hBD18, 16'hA820,
		16'h9720, 16'h7DD0, 16'h6480, 16'h53A0, 16'h3E88};
	localparam logic [10:0][CNT_W-1:0] K_SHORT = {
		16'h0C00, 16'h3798, 16'h3360, 16'h3090, 16'h2DC0, 16'h2988,
		16'h2550, 16'h1B78, 16'h18A8, 16'h1470, 16'h0C00};
	localparam logic [3:0] CR_MAX = 4'hA;

	// outer parity register
	localparam int OUTER_W = 16;
	localparam logic [OUTER_W-1:0] OUTER_POLY = 16'h1021;
	localparam logic [OUTER_W-1:0] OUTER_SEED = 16'h0000;

	// interleaver group sizes per modulation
	localparam logic [2:0] COLS_QPSK = 3'h1;
	localparam logic [2:0] COLS_8PSK = 3'h3;
	localparam logic [2:0] COLS_16APSK = 3'h4;
	localparam logic [2:0] COLS_32APSK = 3'h5;
	localparam int ILV_MAX = 5;

	typedef enum logic [1:0] {
		MOD_QPSK = 2'b00,
		MOD_8PSK = 2'b01,
		MOD_16APSK = 2'b10,
		MOD_32APSK = 2'b11
	} fes_mod_t;

	typedef enum logic [1:0] {
		ENC_IDLE = 2'b00,
		ENC_DATA = 2'b01,
		ENC_PARITY = 2'b10
	} fes_enc_state_t;

	typedef struct packed {
		logic first;
		logic [PARAM_W-1:0] param;
		logic [DATA_W-1:0] data;
	} fes_item_t;

	localparam int ITEM_W = 1 + PARAM_W + DATA_W;
endpackage

// File: core/fes_encoder.sv
// What this block does
// - everything clocked by one clock, no second domain
// - all control inputs and outputs are active high
// - input buffer, outer coding, inner coding, interleaver, output buffer in order
// - coded frame is 64800 bits normal, 16200 bits short
// - uncoded bits per frame set by code rate and frame size table
// - interleaver pattern for QPSK, 8PSK, 16APSK and 32APSK
// - rate, size and modulation may change on every frame
// - data input width fixed at build time
// - parameter input is 16 bits wide
// - parameter input sampled only at frame start, held for the frame
// - frame start ready high whenever a frame start can be taken
// - frame starts when valid and frame start high while ready
// - frame start ready only high together with input ready
// - data ignored on cycles with input valid low
// - after start, one item accepted per cycle with valid and ready
// - coded output width fixed at build time
// - 16-bit parameter output follows the frame being output
// - output valid high whenever coded output holds an item
// - output does not advance past a shown item while clear to send is low
// - output frame start high while first item of frame is shown
// - outputs hold previous values while clear to send is low and output valid is high
// - clock enable low ignores all inputs except reset, including clear, state kept
// - clear discards work; next cycle both ready outputs high
// - parameter fields: id 15:8, pilot 7, mod 6:5, size 4, rate 3:0

module fes_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk_i,
	input wire logic ce_i,
	input wire logic clr_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic next_in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	wire push = in_valid_i & in_ready_o;
	wire pop = out_valid_o & out_ready_i;

	assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	assign next_in_ready_o = next_count != (AW+1)'(DEPTH);
	assign out_valid_o = count != '0;
	assign out_data_o = mem[rd_ptr];

	always_ff @(posedge sys_clk_i)
	begin
		if (clr_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
		end
		else if (ce_i)
		begin
			if (push)
			begin
				mem[wr_ptr] <= in_data_i;
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= next_count;
			in_ready_o <= next_in_ready_o;
		end
	end
endmodule // fes_fifo

module fes_encoder #(
	parameter int DEPTH = fes_pkg::FIFO_DEPTH,
	parameter logic [fes_pkg::OUTER_W-1:0] POLY = fes_pkg::OUTER_POLY
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic sclr_i,
	input wire logic [fes_pkg::DATA_W-1:0] din_i,
	input wire logic [fes_pkg::PARAM_W-1:0] param_i,
	input wire logic input_valid_i,
	input wire logic frame_start_in_i,
	output logic input_ready_o,
	output logic frame_start_ready_o,
	output logic [fes_pkg::DATA_W-1:0] dout_o,
	output logic [fes_pkg::PARAM_W-1:0] param_o,
	output logic output_valid_o,
	output logic frame_start_out_o,
	input wire logic cts_i
);
	import fes_pkg::*;

	function automatic logic [CNT_W-1:0] uncoded_len(input logic [PARAM_W-1:0] p);
		logic [3:0] cr;
		cr = (p[CR_HI:CR_LO] > CR_MAX) ? 4'h0 : p[CR_HI:CR_LO];
		return p[FS_BIT] ? K_SHORT[cr] : K_NORMAL[cr];
	endfunction

	function automatic logic [CNT_W-1:0] coded_len(input logic [PARAM_W-1:0] p);
		return p[FS_BIT] ? N_SHORT : N_NORMAL;
	endfunction

	function automatic logic [2:0] group_cols(input logic [PARAM_W-1:0] p);
		fes_mod_t m;
		m = fes_mod_t'(p[MT_HI:MT_LO]);
		unique case (m)
			MOD_QPSK: return COLS_QPSK;
			MOD_8PSK: return COLS_8PSK;
			MOD_16APSK: return COLS_16APSK;
			MOD_32APSK: return COLS_32APSK;
		endcase
	endfunction

	// own reset always wins; the optional clear only counts while enabled
	wire clr = rst_i | (ce_i & sclr_i);
	wire run = ce_i & ~clr;

	// input side
	fes_item_t in_item;
	fes_item_t enc_item;
	logic in_active;
	logic [CNT_W-1:0] in_count;
	logic [CNT_W-1:0] in_target;
	logic [PARAM_W-1:0] in_param;
	logic in_fifo_next_ready;
	logic enc_pop;
	logic enc_in_valid;

	wire start_hit = input_valid_i & frame_start_in_i & frame_start_ready_o;
	wire take_in = input_valid_i & input_ready_o & (in_active | start_hit);
	wire [CNT_W-1:0] in_count_inc = in_count + CNT_W'(DATA_W);
	wire in_last = in_active ? (in_count_inc == in_target)
		: (CNT_W'(DATA_W) == uncoded_len(param_i));
	wire next_in_active = take_in ? ~in_last : in_active;

	assign in_item.first = ~in_active;
	assign in_item.param = in_active ? in_param : param_i;
	assign in_item.data = din_i;

	fes_fifo #(
		.WIDTH(ITEM_W),
		.DEPTH(DEPTH)
	) u_in_fifo (
		.sys_clk_i(sys_clk_i),
		.ce_i(ce_i),
		.clr_i(clr),
		.in_valid_i(take_in),
		.in_data_i(in_item),
		.in_ready_o(input_ready_o),
		.next_in_ready_o(in_fifo_next_ready),
		.out_valid_o(enc_in_valid),
		.out_data_o(enc_item),
		.out_ready_i(enc_pop)
	);

	always_ff @(posedge sys_clk_i)
	begin
		if (clr)
		begin
			in_active <= 1'b0;
			in_count <= '0;
			in_target <= '0;
			in_param <= '0;
			frame_start_ready_o <= 1'b1;
		end
		else if (ce_i)
		begin
			if (take_in && !in_active)
			begin
				in_param <= param_i;
				in_target <= uncoded_len(param_i);
				in_count <= CNT_W'(DATA_W);
			end
			else if (take_in)
				in_count <= in_count_inc;
			in_active <= next_in_active;
			frame_start_ready_o <= ~next_in_active & in_fifo_next_ready;
		end
	end

	// outer and inner coding
	fes_enc_state_t enc_state;
	logic [CNT_W-1:0] enc_count;
	logic [CNT_W-1:0] enc_k;
	logic [CNT_W-1:0] enc_n;
	logic [OUTER_W-1:0] outer_reg;
	logic inner_acc;
	logic ilv_ready;

	wire enc_sys = enc_state != ENC_PARITY;
	wire enc_out_valid = enc_sys ? enc_in_valid : 1'b1;
	wire enc_fire = enc_out_valid & ilv_ready;
	assign enc_pop = enc_sys & enc_fire;
	wire enc_first = (enc_state == ENC_IDLE) & enc_item.first;
	wire [OUTER_W-1:0] outer_in = (enc_state == ENC_IDLE) ? OUTER_SEED : outer_reg;
	wire [OUTER_W-1:0] outer_next = {outer_in[OUTER_W-2:0], 1'b0}
		^ ((outer_in[OUTER_W-1] ^ enc_item.data[0]) ? POLY : '0);
	wire parity_bit = outer_reg[OUTER_W-1] ^ inner_acc;
	wire enc_bit = enc_sys ? enc_item.data[0] : parity_bit;
	wire [CNT_W-1:0] enc_count_inc = (enc_state == ENC_IDLE) ? CNT_W'(1) : enc_count + 1'b1;
	wire [CNT_W-1:0] enc_k_cur = (enc_state == ENC_IDLE) ? uncoded_len(enc_item.param) : enc_k;

	always_ff @(posedge sys_clk_i)
	begin
		if (clr)
		begin
			enc_state <= ENC_IDLE;
			enc_count <= '0;
			enc_k <= '0;
			enc_n <= '0;
			outer_reg <= OUTER_SEED;
			inner_acc <= 1'b0;
		end
		else if (run && enc_fire)
		begin
			enc_count <= enc_count_inc;
			unique case (enc_state)
				ENC_IDLE:
				begin
					enc_k <= uncoded_len(enc_item.param);
					enc_n <= coded_len(enc_item.param);
					outer_reg <= outer_next;
					inner_acc <= enc_item.data[0];
					enc_state <= (enc_count_inc == enc_k_cur) ? ENC_PARITY : ENC_DATA;
				end
				ENC_DATA:
				begin
					outer_reg <= outer_next;
					inner_acc <= inner_acc ^ enc_item.data[0];
					if (enc_count_inc == enc_k_cur)
						enc_state <= ENC_PARITY;
				end
				ENC_PARITY:
				begin
					outer_reg <= {outer_reg[OUTER_W-2:0], 1'b0};
					inner_acc <= inner_acc ^ parity_bit;
					if (enc_count_inc == enc_n)
						enc_state <= ENC_IDLE;
				end
				default:
					enc_state <= ENC_IDLE;
			endcase
		end
	end

	// bit interleaver: groups of cols bits leave in reverse order
	logic [ILV_MAX-1:0] ilv_buf;
	logic [2:0] ilv_cnt;
	logic [2:0] ilv_idx;
	logic [2:0] ilv_cols;
	logic ilv_emit;
	logic ilv_first;
	logic [PARAM_W-1:0] ilv_param;
	logic out_fifo_ready;
	fes_item_t ilv_item;
	fes_item_t out_item;
	logic out_fifo_valid;

	assign ilv_ready = ~ilv_emit;
	wire [2:0] ilv_cols_cur = enc_first ? group_cols(enc_item.param) : ilv_cols;
	wire ilv_push = ilv_emit & out_fifo_ready;
	wire ilv_group_full = (ilv_cnt + 3'h1) == ilv_cols_cur;

	assign ilv_item.first = ilv_first & (ilv_idx == ilv_cols - 3'h1);
	assign ilv_item.param = ilv_param;
	assign ilv_item.data = DATA_W'(ilv_buf[ilv_idx]);

	always_ff @(posedge sys_clk_i)
	begin
		if (clr)
		begin
			ilv_buf <= '0;
			ilv_cnt <= '0;
			ilv_idx <= '0;
			ilv_cols <= COLS_QPSK;
			ilv_emit <= 1'b0;
			ilv_first <= 1'b0;
			ilv_param <= '0;
		end
		else if (run)
		begin
			if (enc_fire)
			begin
				ilv_buf[ilv_cnt] <= enc_bit;
				if (ilv_cnt == 3'h0)
					ilv_first <= enc_first;
				if (enc_first)
				begin
					ilv_cols <= ilv_cols_cur;
					ilv_param <= enc_item.param;
				end
				if (ilv_group_full)
				begin
					ilv_emit <= 1'b1;
					ilv_idx <= ilv_cnt;
					ilv_cnt <= '0;
				end
				else
					ilv_cnt <= ilv_cnt + 3'h1;
			end
			else if (ilv_push)
			begin
				if (ilv_idx == 3'h0)
					ilv_emit <= 1'b0;
				else
					ilv_idx <= ilv_idx - 3'h1;
			end
		end
	end

	// output buffer and output register
	wire out_load = out_fifo_valid & (~output_valid_o | cts_i);

	fes_fifo #(
		.WIDTH(ITEM_W),
		.DEPTH(DEPTH)
	) u_out_fifo (
		.sys_clk_i(sys_clk_i),
		.ce_i(ce_i),
		.clr_i(clr),
		.in_valid_i(ilv_push),
		.in_data_i(ilv_item),
		.in_ready_o(out_fifo_ready),
		.next_in_ready_o(),
		.out_valid_o(out_fifo_valid),
		.out_data_o(out_item),
		.out_ready_i(out_load)
	);

	always_ff @(posedge sys_clk_i)
	begin
		if (clr)
		begin
			output_valid_o <= 1'b0;
			frame_start_out_o <= 1'b0;
			dout_o <= '0;
			param_o <= '0;
		end
		else if (ce_i)
		begin
			if (out_load)
			begin
				output_valid_o <= 1'b1;
				frame_start_out_o <= out_item.first;
				dout_o <= out_item.data;
				if (out_item.first)
					param_o <= out_item.param;
			end
			else if (cts_i)
			begin
				output_valid_o <= 1'b0;
				frame_start_out_o <= 1'b0;
			end
			// cts low with a held item: everything keeps its value
		end
	end
endmodule // fes_encoder

// File: dv/fes_encoder_chk.sv
module fes_encoder_chk (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic sclr_i,
	input wire logic input_valid_i,
	input wire logic frame_start_in_i,
	input wire logic input_ready_o,
	input wire logic frame_start_ready_o,
	input wire logic [fes_pkg::DATA_W-1:0] dout_o,
	input wire logic [fes_pkg::PARAM_W-1:0] param_o,
	input wire logic output_valid_o,
	input wire logic frame_start_out_o,
	input wire logic cts_i
);
	timeunit 1ns;
	timeprecision 1ns;
	import fes_pkg::*;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire logic run = ce_i && !sclr_i;
	sequence s_start;
		run && input_valid_i && frame_start_in_i && frame_start_ready_o;
	endsequence
	sequence s_stall;
		run && output_valid_o && !cts_i;
	endsequence
	a_ready_pair: assert property (frame_start_ready_o |-> input_ready_o)
		else $error("frame ready without input ready");
	a_start_busy: assert property (s_start |=> !frame_start_ready_o)
		else $error("frame ready high after start");
	a_stall_hold: assert property (s_stall |=>
		$stable({dout_o, param_o, output_valid_o, frame_start_out_o}))
		else $error("output moved during stall");
	a_ce_freeze: assert property (!ce_i |=>
		$stable({dout_o, param_o, output_valid_o, frame_start_out_o, input_ready_o}))
		else $error("state moved with enable low");
	a_clear_init: assert property (ce_i && sclr_i |=>
		input_ready_o && frame_start_ready_o && !output_valid_o && !frame_start_out_o)
		else $error("clear did not reach initial state");
	a_first_valid: assert property (frame_start_out_o |-> output_valid_o)
		else $error("first flag without valid");
	a_first_once: assert property (run && frame_start_out_o && cts_i |=> !frame_start_out_o)
		else $error("first flag after first taken");
	a_param_load: assert property ($changed(param_o) |-> frame_start_out_o || !output_valid_o)
		else $error("param out changed mid frame");
endmodule // fes_encoder_chk

bind fes_encoder fes_encoder_chk u_chk (
	.sys_clk_i(sys_clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.sclr_i(sclr_i),
	.input_valid_i(input_valid_i),
	.frame_start_in_i(frame_start_in_i),
	.input_ready_o(input_ready_o),
	.frame_start_ready_o(frame_start_ready_o),
	.dout_o(dout_o),
	.param_o(param_o),
	.output_valid_o(output_valid_o),
	.frame_start_out_o(frame_start_out_o),
	.cts_i(cts_i)
);

// File: dv/fes_sink.sv
module fes_sink (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic output_valid_i,
	input wire logic frame_start_i,
	input wire logic [fes_pkg::PARAM_W-1:0] param_i,
	input wire logic [fes_pkg::DATA_W-1:0] data_i,
	output logic cts_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import fes_pkg::*;
	logic [3:0] cyc;
	int nf;
	logic [31:0] len [4];
	logic [PARAM_W-1:0] par [4];
	// signature of the systematic part of the first frame
	logic [31:0] sig;
	// stall one cycle in sixteen
	assign cts_o = (cyc != 4'h0);
	always_ff @(posedge sys_clk_i)
	begin
		cyc <= rst_i ? 4'h0 : cyc + 4'h1;
		if (rst_i)
			nf <= 0;
		else if (output_valid_i && cts_o && frame_start_i)
		begin
			len[nf] <= 32'h1;
			par[nf] <= param_i;
			nf <= nf + 1;
		end
		else if (output_valid_i && cts_o && nf > 0)
			len[nf-1] <= len[nf-1] + 32'h1;
		if (rst_i)
			sig <= '0;
		else if (output_valid_i && cts_o && frame_start_i && nf == 0)
			sig <= 32'(data_i);
		else if (output_valid_i && cts_o && nf == 1 && len[0] < 32'hC00)
			sig <= {sig[30:0], sig[31]} ^ 32'(data_i);
	end
endmodule // fes_sink

// File: dv/fes_encoder_tb.sv
module fes_encoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fes_pkg::*;
	logic sys_clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic ce_i = 1'h1;
	logic sclr_i = 1'h0;
	logic [DATA_W-1:0] din_i = '0;
	logic [PARAM_W-1:0] param_i = '0;
	logic input_valid_i = 1'h0;
	logic frame_start_in_i = 1'h0;
	logic input_ready_o, frame_start_ready_o, output_valid_o, frame_start_out_o, cts_i;
	logic [DATA_W-1:0] dout_o;
	logic [PARAM_W-1:0] param_o;
	int n_mismatch = 0;
	int checks_done = 0;
	logic [31:0] sig_in = '0;
	logic [31:0] sig_a = '0;
	always #5 sys_clk_i = ~sys_clk_i;
	fes_encoder dut (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.sclr_i(sclr_i),
		.din_i(din_i),
		.param_i(param_i),
		.input_valid_i(input_valid_i),
		.frame_start_in_i(frame_start_in_i),
		.input_ready_o(input_ready_o),
		.frame_start_ready_o(frame_start_ready_o),
		.dout_o(dout_o),
		.param_o(param_o),
		.output_valid_o(output_valid_o),
		.frame_start_out_o(frame_start_out_o),
		.cts_i(cts_i)
	);
	fes_sink u_sink (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.output_valid_i(output_valid_o),
		.frame_start_i(frame_start_out_o),
		.param_i(param_o),
		.data_i(dout_o),
		.cts_o(cts_i)
	);
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// k items of the frame, only the first n sent
	task automatic send_frame(input logic [PARAM_W-1:0] p, input int k, input int n);
		int i;
		int t;
		i = 0;
		for (t = 0; t < 60000 && i < n; t++)
		begin
			@(negedge sys_clk_i);
			input_valid_i = input_ready_o && (i > 0 || frame_start_ready_o);
			frame_start_in_i = (i == 0);
			param_i = (i == 0) ? p : 16'hFFFF;
			din_i = DATA_W'(t ^ (t >> 2));
			if (i == 1)
				check("ready after start", frame_start_ready_o, 32'h0);
			if (i == k - 1)
				check("ready at last item", frame_start_ready_o, 32'h0);
			if (input_valid_i)
			begin
				sig_in = {sig_in[30:0], sig_in[31]} ^ 32'(din_i);
				i++;
			end
		end
		@(negedge sys_clk_i);
		input_valid_i = 1'h0;
		check("items sent", i, n);
	endtask
	task automatic wait_out(input int n);
		int t;
		int idle;
		idle = 0;
		for (t = 0; t < 60000 && idle < 16; t++)
		begin
			@(negedge sys_clk_i);
			idle = (u_sink.nf >= n && !output_valid_o) ? idle + 1 : 0;
		end
	endtask
	initial
	begin
		repeat (8) @(negedge sys_clk_i);
		rst_i = 1'h0;
		check("input ready", input_ready_o, 32'h1);
		check("frame ready", frame_start_ready_o, 32'h1);
		check("out valid", output_valid_o, 32'h0);
		send_frame(16'hA590, 3072, 3072);
		sig_a = sig_in;
		send_frame(16'h3C79, 14232, 14232);
		wait_out(2);
		check("frames", u_sink.nf, 32'h2);
		check("len a", u_sink.len[0], 32'h3F48);
		check("len b", u_sink.len[1], 32'h3F48);
		check("param a", u_sink.par[0], 32'hA590);
		check("param b", u_sink.par[1], 32'h3C79);
		check("data a", u_sink.sig, sig_a);
		send_frame(16'h0053, 7032, 40);
		ce_i = 1'h0;
		sclr_i = 1'h1;
		repeat (3) @(negedge sys_clk_i);
		check("enable low", frame_start_ready_o, 32'h0);
		ce_i = 1'h1;
		@(negedge sys_clk_i);
		sclr_i = 1'h0;
		check("clear ready", frame_start_ready_o & input_ready_o, 32'h1);
		check("clear valid", output_valid_o, 32'h0);
		summarize();
	end
	initial
	begin
		repeat (95000) @(posedge sys_clk_i);
		n_mismatch++;
		summarize();
	end
endmodule // fes_encoder_tb
